/* csr_cfg.svh */
// constants for the core special register block
// assumes one 25 MHz clock domain, no bus beyond the core's register port
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH
`define CSR_ADDR_ACC 8'h05
`define CSR_ADDR_PCL 8'h06
`define CSR_ADDR_TABLE_POINTER 8'h07
`define CSR_ADDR_TABLE_HIGH_BYTE 8'h08
`define CSR_ADDR_BANK 8'h04
`define CSR_ADDR_STAT 8'h0a
`define CSR_ADDR_IND1 8'h02
`define CSR_ADDR_PTR1 8'h03
`define CSR_BIT_WDT 5
`define CSR_BIT_HALT 4
`define CSR_BIT_OV 3
`define CSR_BIT_Z 2
`define CSR_BIT_AC 1
`define CSR_BIT_C 0
`define CSR_BANK_RST 8'h00
`define CSR_DUMMY_CYC 2'h1
`endif

/* csr_pkg.sv */
// types for the core special register block
// shared by the register block, the cpu model and the bench
package csr_pkg;
  typedef enum logic [3:0] {
    CSR_OP_NONE = 4'h0,
    CSR_OP_ADD = 4'h1,
    CSR_OP_SUB = 4'h2,
    CSR_OP_LOGIC = 4'h3,
    CSR_OP_RLC = 4'h4,
    CSR_OP_RRC = 4'h5,
    CSR_OP_INCDEC = 4'h6
  } csr_op_t;
  typedef enum logic [1:0] {
    CSR_ST_RUN = 2'b01,
    CSR_ST_DUMMY = 2'b10
  } csr_state_t;
endpackage : csr_pkg

/* csr_core_regs.sv */
// core special registers: bank, acc, pc low, table, status flags
// assumes the decoder drives one instruction per clock on the same clock
`timescale 1ns/1ns
`include "csr_cfg.svh"
// Function
// - bank register keeps bit 0 only, cleared at power-on, upper bits read zero
// - writing pc low replaces low eight pc bits, jump stays in page
// - a pc low write outside the dummy cycle inserts one dummy cycle before continuing; one during it is dropped
// - table pointer gives table read address, changeable like other registers
// - table read puts fetched high byte into table high register
// - alu results land in accumulator; no register to register moves
// - status writes never change watchdog expiry or halt sleep flags
// - watchdog flag set on timeout, cleared by power-up, clear or sleep
// - halt flag set by sleep, cleared by power-up or watchdog clear
// - overflow flag is carry into msb xor carry out of msb
// - zero flag set when result is zero, else cleared
// - half flag is low nibble carry or no nibble borrow
// - carry flag from add carry, sub no-borrow, and rotates through carry
// - status bits 7..6 read zero; system flags zero at power-on
// - status is never saved automatically on interrupt or call
// - direct access always bank 0; bank 1 only through indirect port one
// - resets clear bank except watchdog timeout reset while powered down
module csr_core_regs
  import csr_pkg::*;
#(
  parameter int PC_W = 10
)
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic por_in,
  input wire logic wdt_rst_in,
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic alu_wr_in,
  input wire csr_op_t alu_op_in,
  input wire logic [7:0] alu_a_in,
  input wire logic [7:0] alu_b_in,
  input wire logic inc_in,
  input wire logic dec_in,
  input wire logic tbl_done_in,
  input wire logic [15:0] tbl_word_in,
  input wire logic wdt_clr_in,
  input wire logic halt_in,
  input wire logic wdt_tmo_in,
  input wire logic pc_step_in,
  output logic [7:0] rdata_out,
  output logic [PC_W-1:0] pc_out,
  output logic stall_out,
  output logic [7:0] tbl_addr_out,
  output logic [7:0] tbl_low_out,
  output logic tbl_low_vld_out,
  output logic data_bank_select_bit_out,
  output logic direct_bank_out,
  output logic ind_bank_out
);
  // the page split needs at least one pc bit above the low byte
  if (PC_W < 9 || PC_W > 16)
  begin : g_pc_w_chk
    $error("csr_core_regs: PC_W must be 9..16");
  end

  logic [7:0] acc_r;
  logic [7:0] table_pointer_r;
  logic [7:0] table_high_byte_r;
  logic data_bank_select_bit_r;
  logic [7:0] flags_r;
  logic [PC_W-1:0] pc_r;
  csr_state_t state_r;
  logic halted_r;
  logic [7:0] rdata_r;
  logic [7:0] res_nxt;
  logic c_nxt, ac_nxt, ov_nxt;
  logic def_c, def_ac, def_ov, def_z;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] sum7;
  logic [7:0] bopnd;
  logic cin;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = wr_en_in && (a == ref_a);
  endfunction : hit

  // add and sub share one adder; sub is a + ~b + 1 so carry means no borrow
  always_comb
  begin
    bopnd = (alu_op_in == CSR_OP_SUB) ? ~alu_b_in : alu_b_in;
    cin = (alu_op_in == CSR_OP_SUB);
    sum9 = {1'b0, alu_a_in} + {1'b0, bopnd} + {8'h00, cin};
    sum5 = {1'b0, alu_a_in[3:0]} + {1'b0, bopnd[3:0]} + {4'h0, cin};
    sum7 = {1'b0, alu_a_in[6:0]} + {1'b0, bopnd[6:0]} + {7'h00, cin};
    res_nxt = alu_b_in;
    c_nxt = flags_r[`CSR_BIT_C];
    ac_nxt = flags_r[`CSR_BIT_AC];
    ov_nxt = flags_r[`CSR_BIT_OV];
    def_c = 1'b0;
    def_ac = 1'b0;
    def_ov = 1'b0;
    def_z = 1'b0;
    case (alu_op_in)
      CSR_OP_ADD, CSR_OP_SUB:
      begin
        res_nxt = sum9[7:0];
        c_nxt = sum9[8];
        ac_nxt = sum5[4];
        ov_nxt = sum7[7] ^ sum9[8];
        def_c = 1'b1;
        def_ac = 1'b1;
        def_ov = 1'b1;
        def_z = 1'b1;
      end
      CSR_OP_LOGIC, CSR_OP_INCDEC:
      begin
        res_nxt = alu_a_in;
        def_z = 1'b1;
      end
      CSR_OP_RLC:
      begin
        res_nxt = {alu_a_in[6:0], flags_r[`CSR_BIT_C]};
        c_nxt = alu_a_in[7];
        def_c = 1'b1;
      end
      CSR_OP_RRC:
      begin
        res_nxt = {flags_r[`CSR_BIT_C], alu_a_in[7:1]};
        c_nxt = alu_a_in[0];
        def_c = 1'b1;
      end
      default:
      begin
        res_nxt = alu_b_in;
      end
    endcase
  end

  // accumulator is the only alu destination; no reg to reg path exists
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      acc_r <= 8'h00;
    else if (alu_wr_in && alu_op_in != CSR_OP_NONE)
      acc_r <= res_nxt;
    else if (hit(addr_in, `CSR_ADDR_ACC))
      acc_r <= wdata_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      table_pointer_r <= 8'h00;
    else if (hit(addr_in, `CSR_ADDR_TABLE_POINTER))
      table_pointer_r <= wdata_in;
    else if (inc_in && addr_in == `CSR_ADDR_TABLE_POINTER)
      table_pointer_r <= table_pointer_r + 8'h01;
    else if (dec_in && addr_in == `CSR_ADDR_TABLE_POINTER)
      table_pointer_r <= table_pointer_r - 8'h01;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      table_high_byte_r <= 8'h00;
    else if (tbl_done_in)
      table_high_byte_r <= tbl_word_in[15:8];
    else if (hit(addr_in, `CSR_ADDR_TABLE_HIGH_BYTE))
      table_high_byte_r <= wdata_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      tbl_low_out <= 8'h00;
      tbl_low_vld_out <= 1'b0;
    end
    else
    begin
      tbl_low_out <= tbl_word_in[7:0];
      tbl_low_vld_out <= tbl_done_in;
    end
  end

  // halted marks power down so a wdt reset then keeps the bank
  always_ff @(posedge mclk_in)
  begin
    if (srst_in || por_in)
      halted_r <= 1'b0;
    else if (halt_in)
      halted_r <= 1'b1;
    else if (wdt_clr_in || (wdt_rst_in && halted_r))
      halted_r <= 1'b0;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in || por_in)
      data_bank_select_bit_r <= 1'(`CSR_BANK_RST);
    else if (wdt_rst_in && !halted_r)
      data_bank_select_bit_r <= 1'b0;
    else if (hit(addr_in, `CSR_ADDR_BANK))
      data_bank_select_bit_r <= wdata_in[0];
  end

  // status is not stacked on calls; software saves it itself
  always_ff @(posedge mclk_in)
  begin
    if (srst_in || por_in)
      flags_r <= 8'h00;
    else
    begin
      if (wdt_tmo_in)
        flags_r[`CSR_BIT_WDT] <= 1'b1;
      else if (wdt_clr_in || halt_in)
        flags_r[`CSR_BIT_WDT] <= 1'b0;
      if (halt_in)
        flags_r[`CSR_BIT_HALT] <= 1'b1;
      else if (wdt_clr_in)
        flags_r[`CSR_BIT_HALT] <= 1'b0;
      if (alu_wr_in)
      begin
        if (def_c)
          flags_r[`CSR_BIT_C] <= c_nxt;
        if (def_ac)
          flags_r[`CSR_BIT_AC] <= ac_nxt;
        if (def_ov)
          flags_r[`CSR_BIT_OV] <= ov_nxt;
        if (def_z)
          flags_r[`CSR_BIT_Z] <= (res_nxt == 8'h00);
      end
      else if (hit(addr_in, `CSR_ADDR_STAT))
        flags_r[3:0] <= wdata_in[3:0];
    end
  end

  // pc low write costs a dummy cycle while the new fetch is issued
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      pc_r <= '0;
      state_r <= CSR_ST_RUN;
    end
    else
    begin
      case (state_r)
        CSR_ST_RUN:
        begin
          if (hit(addr_in, `CSR_ADDR_PCL))
          begin
            pc_r <= {pc_r[PC_W-1:8], wdata_in};
            state_r <= CSR_ST_DUMMY;
          end
          else if (pc_step_in)
            pc_r <= pc_r + {{(PC_W-1){1'b0}}, 1'b1};
        end
        CSR_ST_DUMMY:
          state_r <= CSR_ST_RUN;
        default:
          state_r <= CSR_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      rdata_r <= 8'h00;
    else
    begin
      case (addr_in)
        `CSR_ADDR_ACC: rdata_r <= acc_r;
        `CSR_ADDR_PCL: rdata_r <= pc_r[7:0];
        `CSR_ADDR_TABLE_POINTER: rdata_r <= table_pointer_r;
        `CSR_ADDR_TABLE_HIGH_BYTE: rdata_r <= table_high_byte_r;
        `CSR_ADDR_BANK: rdata_r <= {7'h00, data_bank_select_bit_r};
        `CSR_ADDR_STAT: rdata_r <= {2'b00, flags_r[5:0]};
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      direct_bank_out <= 1'b0;
      ind_bank_out <= 1'b0;
    end
    else
    begin
      direct_bank_out <= 1'b0;
      ind_bank_out <= (addr_in == `CSR_ADDR_IND1) && data_bank_select_bit_r;
    end
  end

  assign rdata_out = rdata_r;
  assign pc_out = pc_r;
  assign stall_out = (state_r == CSR_ST_DUMMY);
  assign tbl_addr_out = table_pointer_r;
  assign data_bank_select_bit_out = data_bank_select_bit_r;

  // decodes written out here so every term is a sampled value
  bank_reads_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    addr_in == `CSR_ADDR_BANK
      |=> rdata_out[7:1] == 7'h00 && rdata_out[0] == $past(data_bank_select_bit_r))
    else $error("bank read wrong");
  pcl_jump_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    state_r == CSR_ST_RUN && wr_en_in && addr_in == `CSR_ADDR_PCL
      |=> pc_out[7:0] == $past(wdata_in) && pc_out[PC_W-1:8] == $past(pc_r[PC_W-1:8]))
    else $error("pc low jump wrong");
  dummy_cycle_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    state_r == CSR_ST_RUN && wr_en_in && addr_in == `CSR_ADDR_PCL |=> stall_out ##1 !stall_out)
    else $error("dummy cycle not one");
  tbl_high_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    tbl_done_in |=> table_high_byte_r == $past(tbl_word_in[15:8]))
    else $error("table high not loaded");
  sys_flags_a: assert property (@(posedge mclk_in) disable iff (srst_in || por_in)
    wr_en_in && addr_in == `CSR_ADDR_STAT && !halt_in && !wdt_clr_in && !wdt_tmo_in
      |=> flags_r[5:4] == $past(flags_r[5:4]))
    else $error("system flags written");
  wdt_flag_a: assert property (@(posedge mclk_in) disable iff (srst_in || por_in)
    wdt_tmo_in |=> flags_r[`CSR_BIT_WDT])
    else $error("watchdog flag not set");
  halt_flag_a: assert property (@(posedge mclk_in) disable iff (srst_in || por_in)
    halt_in |=> (flags_r[`CSR_BIT_HALT] && !flags_r[`CSR_BIT_WDT]) || $past(wdt_tmo_in))
    else $error("halt flag wrong");
  add_flags_a: assert property (@(posedge mclk_in) disable iff (srst_in || por_in)
    alu_wr_in && alu_op_in == CSR_OP_ADD |=> flags_r[`CSR_BIT_C] == $past(sum9[8])
      && flags_r[`CSR_BIT_Z] == ($past(sum9[7:0]) == 8'h00))
    else $error("add flags wrong");
  sub_borrow_a: assert property (@(posedge mclk_in) disable iff (srst_in || por_in)
    alu_wr_in && alu_op_in == CSR_OP_SUB
      |=> flags_r[`CSR_BIT_C] == ($past(alu_a_in) >= $past(alu_b_in))
      && flags_r[`CSR_BIT_AC] == ($past(alu_a_in[3:0]) >= $past(alu_b_in[3:0])))
    else $error("sub borrow flags wrong");
  logic_zero_a: assert property (@(posedge mclk_in) disable iff (srst_in || por_in)
    alu_wr_in && alu_op_in == CSR_OP_LOGIC
      |=> flags_r[`CSR_BIT_Z] == ($past(alu_a_in) == 8'h00) && $stable(flags_r[`CSR_BIT_C]))
    else $error("logic zero flag wrong");
  bank_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in || por_in)
    wdt_rst_in && halted_r && !wr_en_in |=> $stable(data_bank_select_bit_r))
    else $error("bank lost in power down");
  pcl_cov_c: cover property (@(posedge mclk_in) wr_en_in && addr_in == `CSR_ADDR_PCL ##2 !stall_out);
  tbl_cov_c: cover property (@(posedge mclk_in) tbl_done_in ##1 tbl_low_vld_out);
  sub_cov_c: cover property (@(posedge mclk_in) alu_wr_in && alu_op_in == CSR_OP_SUB);
  halt_cov_c: cover property (@(posedge mclk_in) halt_in ##[1:20] wdt_rst_in);
endmodule : csr_core_regs

/* csr_cpu_model.sv */
// far-side model: decoder and alu issuing one operation per clock edge
// assumes the register block samples all its inputs on rising mclk_in
`timescale 1ns/1ns
`include "csr_cfg.svh"
module csr_cpu_model
  import csr_pkg::*;
(
  input wire logic mclk_in,
  output logic por_out,
  output logic wdt_rst_out,
  output logic wr_en_out,
  output logic alu_wr_out,
  output logic inc_out,
  output logic dec_out,
  output logic tbl_done_out,
  output logic wdt_clr_out,
  output logic halt_out,
  output logic wdt_tmo_out,
  output logic pc_step_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output csr_op_t alu_op_out,
  output logic [7:0] alu_b_out,
  output logic [15:0] tbl_word_out
);
  logic [10:0] stb_r = 11'h000;
  logic pcl_r = 1'b0;
  assign {por_out, wdt_rst_out, wr_en_out, alu_wr_out, inc_out, dec_out, tbl_done_out,
    wdt_clr_out, halt_out, wdt_tmo_out, pc_step_out} = stb_r;
  assign tbl_word_out = {alu_b_out, wdata_out};
  initial
  begin
    {addr_out, wdata_out, alu_b_out} = 24'h000000;
    alu_op_out = CSR_OP_NONE;
  end
  // the decoder idles through the dummy cycle itself, so nothing is lost there
  task automatic issue(input logic [10:0] st, input logic [7:0] a, input logic [7:0] d,
    input csr_op_t op, input logic [7:0] b);
    @(posedge mclk_in);
    if (pcl_r)
    begin
      stb_r <= 11'h000;
      @(posedge mclk_in);
    end
    stb_r <= st;
    addr_out <= a;
    wdata_out <= d;
    alu_op_out <= op;
    alu_b_out <= b;
    pcl_r = st[8] && a == `CSR_ADDR_PCL;
  endtask : issue
endmodule : csr_cpu_model

/* cpu_special_registers_test.sv */
// self-checking bench for the core special register block
// assumes csr_core_regs and csr_cpu_model are compiled before it
`timescale 1ns/1ns
`include "csr_cfg.svh"
module cpu_special_registers_test
  import csr_pkg::*;
;
  typedef struct {int due; int kind; logic [7:0] exp;} csr_note_t;
  localparam logic [10:0] S_POR = 11'h400, S_WRST = 11'h200, S_WR = 11'h100, S_ALU = 11'h080;
  localparam logic [10:0] S_INC = 11'h040, S_DEC = 11'h020, S_TBL = 11'h010, S_CLR = 11'h008;
  localparam logic [10:0] S_HALT = 11'h004, S_TMO = 11'h002, S_STEP = 11'h001, S_NO = 11'h000;
  localparam logic [7:0] A_BK = `CSR_ADDR_BANK, A_ST = `CSR_ADDR_STAT, A_PC = `CSR_ADDR_PCL;
  localparam logic [7:0] A_TP = `CSR_ADDR_TABLE_POINTER, A_TH = `CSR_ADDR_TABLE_HIGH_BYTE, A_AC = `CSR_ADDR_ACC;
  logic mclk, srst, por, wrst, wr, alw, inc, dec, tdn, wclr, hlt, tmo, stp, stall, tlv;
  logic bsel, dbk, ibk;
  logic [7:0] adr, wd, ob, rdq, tba, tlo, x, a, b, r;
  logic [15:0] tw;
  logic [9:0] pc;
  logic [8:0] s9;
  logic [4:0] h5;
  csr_op_t opc, o;
  logic wx_e = 1'b0, hs_e = 1'b0, sw_e = 1'b0, z_e = 1'b0, nh_e = 1'b0, c_e = 1'b0;
  int seed = 96104, errors = 0, n_checks = 0, cyc = 0;
  csr_note_t notes[$], nt;
  csr_op_t ops[5] = '{CSR_OP_ADD, CSR_OP_SUB, CSR_OP_LOGIC, CSR_OP_RLC, CSR_OP_RRC};
  logic [10:0] seq[5] = '{S_TMO, S_HALT, S_WR, S_TMO, S_CLR};
  string nm[6] = '{"rdata", "pc_low", "stall", "bank", "tbl_addr", "tbl_low"};
  csr_core_regs #(.PC_W(10)) csr_core_regs_i (.mclk_in(mclk), .srst_in(srst), .por_in(por),
    .wdt_rst_in(wrst), .wr_en_in(wr), .addr_in(adr), .wdata_in(wd), .alu_wr_in(alw),
    .alu_op_in(opc), .alu_a_in(wd), .alu_b_in(ob), .inc_in(inc), .dec_in(dec),
    .tbl_done_in(tdn), .tbl_word_in(tw), .wdt_clr_in(wclr), .halt_in(hlt), .wdt_tmo_in(tmo),
    .pc_step_in(stp), .rdata_out(rdq), .pc_out(pc), .stall_out(stall), .tbl_addr_out(tba),
    .tbl_low_out(tlo), .tbl_low_vld_out(tlv), .data_bank_select_bit_out(bsel),
    .direct_bank_out(dbk), .ind_bank_out(ibk));
  csr_cpu_model csr_cpu_model_i (.mclk_in(mclk), .por_out(por), .wdt_rst_out(wrst),
    .wr_en_out(wr), .alu_wr_out(alw), .inc_out(inc), .dec_out(dec), .tbl_done_out(tdn),
    .wdt_clr_out(wclr), .halt_out(hlt), .wdt_tmo_out(tmo), .pc_step_out(stp),
    .addr_out(adr), .wdata_out(wd), .alu_op_out(opc), .alu_b_out(ob), .tbl_word_out(tw));
  task automatic test_done();
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic cmp(input int k, input logic [7:0] e);
    logic [7:0] s;
    case (k)
      0: s = rdq;
      1: s = pc[7:0];
      2: s = {7'h00, stall};
      3: s = {5'h00, ibk, dbk, bsel};
      4: s = tba;
      default: s = (tlv === 1'b1) ? tlo : 8'hxx;
    endcase
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm[k], e, s);
    end
  endtask : cmp
  // a note falls due a fixed number of edges after the request that caused it
  task automatic chk(input int k, input logic [7:0] e, input int lag);
    notes.push_back('{cyc + lag, k, e});
  endtask : chk
  task automatic op(input logic [10:0] st, input logic [7:0] ad, input logic [7:0] d,
    input csr_op_t c = CSR_OP_NONE, input logic [7:0] bb = 8'h00);
    csr_cpu_model_i.issue(st, ad, d, c, bb);
  endtask : op
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    op(S_NO, ad, 8'h00);
    chk(0, e, 2);
  endtask : rd
  function automatic logic [7:0] stat();
    return {2'b00, wx_e, hs_e, sw_e, z_e, nh_e, c_e};
  endfunction : stat
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    while (notes.size() > 0 && notes[0].due <= cyc)
    begin
      nt = notes.pop_front();
      cmp(nt.kind, nt.exp);
    end
  end
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    #(40 * 3000);
    errors++;
    test_done();
  end
  initial
  begin
    srst = 1'b1;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    rd(A_ST, 8'h00);
    op(S_WR, A_BK, 8'hff);
    rd(A_BK, 8'h01);
    op(S_NO, `CSR_ADDR_IND1, 8'h00);
    chk(3, 8'h05, 2);
    op(S_WRST, A_BK, 8'h00);
    rd(A_BK, 8'h00);
    x = 8'($random(seed));
    op(S_WR, A_TP, x);
    op(S_INC, A_TP, 8'h00);
    chk(4, x + 8'h01, 2);
    op(S_DEC, A_TP, 8'h00);
    op(S_DEC, A_TP, 8'h00);
    chk(4, x - 8'h01, 2);
    a = 8'($random(seed));
    b = 8'($random(seed));
    op(S_TBL, A_TH, a, CSR_OP_NONE, b);
    chk(5, a, 2);
    rd(A_TH, b);
    // crossing the page first makes a lost upper pc visible
    op(S_WR, A_PC, 8'hff);
    op(S_STEP, 8'h00, 8'h00);
    x = 8'($random(seed));
    op(S_WR, A_PC, x);
    chk(1, x, 2);
    chk(2, 8'h01, 2);
    chk(2, 8'h00, 3);
    op(S_WR, A_AC, ~x);
    rd(A_AC, ~x);
    if (pc[9:8] !== 2'b01)
      chk(1, 8'hxx, 1);
    for (int i = 0; i < 30; i++)
    begin
      o = ops[i % 5];
      a = (o == CSR_OP_LOGIC) ? 8'h00 : 8'($random(seed));
      b = (o == CSR_OP_LOGIC) ? 8'h00 : 8'($random(seed));
      s9 = (o == CSR_OP_SUB) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
      h5 = (o == CSR_OP_SUB) ? {1'b0, a[3:0]} - {1'b0, b[3:0]}
        : {1'b0, a[3:0]} + {1'b0, b[3:0]};
      r = (o == CSR_OP_RLC) ? {a[6:0], c_e} : (o == CSR_OP_RRC) ? {c_e, a[7:1]} : s9[7:0];
      if (o == CSR_OP_ADD || o == CSR_OP_SUB)
      begin
        c_e = s9[8] ^ (o == CSR_OP_SUB);
        nh_e = h5[4] ^ (o == CSR_OP_SUB);
        sw_e = (a[7] ^ r[7]) & (a[7] ^ b[7] ^ (o == CSR_OP_ADD));
      end
      if (o == CSR_OP_RLC || o == CSR_OP_RRC)
        c_e = (o == CSR_OP_RLC) ? a[7] : a[0];
      else
        z_e = (r == 8'h00);
      op(S_ALU, A_ST, a, o, b);
      rd(A_AC, r);
      rd(A_ST, stat());
    end
    foreach (seq[j])
    begin
      op(seq[j], A_ST, 8'hff);
      case (seq[j])
        S_TMO: wx_e = 1'b1;
        S_HALT: {wx_e, hs_e} = 2'b01;
        S_CLR: {wx_e, hs_e} = 2'b00;
        default: {sw_e, z_e, nh_e, c_e} = 4'hf;
      endcase
      rd(A_ST, stat());
    end
    op(S_WR, A_BK, 8'h01);
    op(S_HALT, A_BK, 8'h00);
    op(S_WRST, A_BK, 8'h00);
    rd(A_BK, 8'h01);
    op(S_POR, A_BK, 8'h00);
    rd(A_BK, 8'h00);
    rd(A_ST, 8'h00);
    repeat (4) @(posedge mclk);
    test_done();
  end
endmodule : cpu_special_registers_test
